// ==== design/uefc_top.sv ====
// Enhanced flow control block: registers, auto CTS/RTS, flow characters.
// Assumes RX_LEVEL, RX_IN and TX_BUSY come from logic on REF_CLK; CTS_PIN is a pin.
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module uefc_top
  import uefc_pkg::*;
#(
  parameter int LVL_W = 8
) (
  input  wire logic        REF_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             IRQ,
  input  wire logic        CTS_PIN,
  output logic             RTS_PIN,
  input  wire logic [LVL_W-1:0] RX_LEVEL,
  input  wire uefc_char_s  RX_IN,
  output uefc_char_s       RX_STORE,
  input  wire logic        TX_BUSY,
  output logic             TX_HALT,
  output uefc_char_s       TX_FC,
  input  wire logic        TX_FC_READY
);

  // Level width must hold every threshold code
  if (LVL_W < 8) begin : g_chk
    $error("LVL_W must be at least 8");
  end

  logic [7:0] enh_q, res1_q, res2_q, pau1_q, pau2_q;
  logic [7:0] irqen_q, fifoc_q, modem_q, rxtrig_q, flowhi_q, flowlo_q;
  logic [7:0] stat_q, mask_q;
  logic       pready_q, pslverr_q, irq_q;
  logic [31:0] prdata_q;
  logic       cts_m_q, cts_q, cts_prev_q;
  logic       rts_hold_q, rts_q, trig_prev_q;
  logic       halt_q, sw_paused_q, half_p_q, half_r_q;
  logic       xoff_prev_q;
  uefc_char_s store_q, fc_q;
  uefc_snd_e  snd_q, snd_d;
  logic       snd_pause_q;

  // Bus decode; answer one cycle into the access phase
  wire        acc     = PSEL && PENABLE;
  wire        pready_d = acc && !pready_q;
  wire        wr_done = acc && pready_q && PWRITE;
  wire [7:0]  wd      = PWDATA[7:0];
  wire        gate    = enh_q[ENH_GATE];
  wire        hit     = (PADDR[1:0] == 2'b00) && (PADDR <= OFS_STATE);
  wire        w_enh   = wr_done && PADDR == OFS_ENH;
  wire        w_stat  = wr_done && PADDR == OFS_STAT;

  // Threshold codes 0 and 1 both mean one character
  function automatic logic [LVL_W-1:0] thr(input logic [7:0] v);
    thr = (v == 8'h00) ? LVL_W'(1) : LVL_W'(v);
  endfunction

  wire lvl_trig = RX_LEVEL >= thr(rxtrig_q);
  wire lvl_hi   = RX_LEVEL >= thr(flowhi_q);
  wire lvl_lo   = RX_LEVEL <  thr(flowlo_q);

  // Receive compare select; dual sequence only when every select bit is set
  wire [1:0] rx_sel  = enh_q[1:0];
  wire [1:0] tx_sel  = enh_q[3:2];
  wire       dual_rx = enh_q[3:0] == 4'hF;
  wire       m_p1    = RX_IN.data == pau1_q;
  wire       m_p2    = RX_IN.data == pau2_q;
  wire       m_r1    = RX_IN.data == res1_q;
  wire       m_r2    = RX_IN.data == res2_q;
  wire       p_one   = (rx_sel[1] && m_p1) || (rx_sel[0] && m_p2);
  wire       r_one   = (rx_sel[1] && m_r1) || (rx_sel[0] && m_r2);
  wire       p_hit   = RX_IN.valid && (dual_rx ? (half_p_q && m_p2) : p_one);
  wire       r_hit   = RX_IN.valid && (dual_rx ? (half_r_q && m_r2) : r_one);
  wire       fc_char = RX_IN.valid && rx_sel != 2'b00 && (p_one || r_one);
  wire       special = RX_IN.valid && enh_q[ENH_SPECIAL] && m_p2;

  // Transmit halt request from CTS or a received pause sequence
  wire halt_want = (enh_q[ENH_AUTO_CTS] && cts_q) || sw_paused_q;

  // Hardware events into the sticky status
  wire [7:0] ev;
  assign ev[ST_RXTRIG]  = enh_q[ENH_AUTO_RTS] && lvl_trig && !trig_prev_q;
  assign ev[ST_CTSCHG]  = cts_q != cts_prev_q;
  assign ev[ST_RTSCHG]  = rts_hold_q != rts_q && enh_q[ENH_AUTO_RTS];
  assign ev[3]          = 1'b0;
  assign ev[ST_SPECIAL] = special;
  assign ev[ST_FLOWCH]  = p_hit || r_hit;
  assign ev[7:6]        = 2'b00;
  wire [7:0] clr_mask   = gate ? 8'hFF : ~ST_LOCK;
  wire [7:0] stat_d     = ev | (stat_q & ~(w_stat ? (wd & clr_mask) : 8'h00));

  // Lockable writes keep old enhanced bits while the gate is shut
  function automatic logic [7:0] lk(input logic [7:0] o, input logic [7:0] n,
                                    input logic [7:0] m, input logic g);
    lk = g ? n : ((o & m) | (n & ~m));
  endfunction

  // Read mux; auto RTS bit shows whether flow is currently allowed
  wire [7:0] enh_rd = {enh_q[7], enh_q[ENH_AUTO_RTS] && !rts_hold_q, enh_q[5:0]};
  logic [7:0] rd;
  always_comb begin
    case (PADDR)
      OFS_ENH:    rd = enh_rd;
      OFS_RES1:   rd = res1_q;
      OFS_RES2:   rd = res2_q;
      OFS_PAU1:   rd = pau1_q;
      OFS_PAU2:   rd = pau2_q;
      OFS_IRQEN:  rd = irqen_q;
      OFS_FIFOC:  rd = fifoc_q;
      OFS_MODEM:  rd = modem_q;
      OFS_RXTRIG: rd = rxtrig_q;
      OFS_FLOWHI: rd = flowhi_q;
      OFS_FLOWLO: rd = flowlo_q;
      OFS_STAT:   rd = stat_q;
      OFS_MASK:   rd = mask_q;
      OFS_STATE:  rd = {4'h0, sw_paused_q, halt_q, rts_q, cts_q};
      default:    rd = RST_BYTE;
    endcase
  end

  // APB handshake and read data
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= RST_WORD;
    end else begin
      pready_q  <= pready_d;
      pslverr_q <= pready_d && !hit;
      if (pready_d) begin
        prdata_q <= (hit && !PWRITE) ? {24'h00_0000, rd} : RST_WORD;
      end
    end
  end

  // Register file; gate bit clears on reset so enhanced bits start locked
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      enh_q    <= RST_BYTE;
      {res1_q, res2_q, pau1_q, pau2_q} <= RST_WORD;
      {irqen_q, fifoc_q, modem_q, mask_q} <= RST_WORD;
      {rxtrig_q, flowhi_q, flowlo_q}   <= 24'h00_0000;
      stat_q   <= RST_BYTE;
    end else begin
      stat_q <= stat_d;
      if (w_enh) enh_q <= wd;
      if (wr_done) begin
        case (PADDR)
          OFS_RES1:   res1_q   <= wd;
          OFS_RES2:   res2_q   <= wd;
          OFS_PAU1:   pau1_q   <= wd;
          OFS_PAU2:   pau2_q   <= wd;
          OFS_IRQEN:  irqen_q  <= lk(irqen_q, wd, IRQEN_LOCK, gate);
          OFS_FIFOC:  fifoc_q  <= lk(fifoc_q, wd, FIFOC_LOCK, gate);
          OFS_MODEM:  modem_q  <= lk(modem_q, wd, MODEM_LOCK, gate);
          OFS_RXTRIG: rxtrig_q <= wd;
          OFS_FLOWHI: flowhi_q <= wd;
          OFS_FLOWLO: flowlo_q <= wd;
          OFS_MASK:   mask_q   <= wd;
          default:    ;
        endcase
      end
    end
  end

  // CTS pin synchroniser; only the second stage is read
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cts_m_q    <= 1'b0;
      cts_q      <= 1'b0;
      cts_prev_q <= 1'b0;
    end else begin
      cts_m_q    <= CTS_PIN;
      cts_q      <= cts_m_q;
      cts_prev_q <= cts_q;
    end
  end

  // Auto RTS hysteresis between the high and low thresholds
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rts_hold_q  <= 1'b0;
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= lvl_trig;
      if (lvl_hi) begin
        rts_hold_q <= 1'b1;
      end else if (lvl_lo) begin
        rts_hold_q <= 1'b0;
      end
    end
  end

  // RTS pin: flow state when enabled, else the inverse of the software modem control bit
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rts_q <= 1'b1;
    end else begin
      rts_q <= enh_q[ENH_AUTO_RTS] ? rts_hold_q : !modem_q[MODEM_RTS];
    end
  end

  // Halt only between characters so no partial character leaves
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      halt_q <= 1'b0;
    end else if (!halt_want) begin
      halt_q <= 1'b0;
    end else if (!TX_BUSY) begin
      halt_q <= 1'b1;
    end
  end

  // Received flow sequences; first half waits for the next character
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sw_paused_q <= 1'b0;
      half_p_q    <= 1'b0;
      half_r_q    <= 1'b0;
      store_q     <= '0;
    end else begin
      if (RX_IN.valid) begin
        half_p_q <= dual_rx && m_p1;
        half_r_q <= dual_rx && m_r1;
      end
      if (rx_sel == 2'b00) begin
        sw_paused_q <= 1'b0;
      end else if (p_hit) begin
        sw_paused_q <= 1'b1;
      end else if (r_hit) begin
        sw_paused_q <= 1'b0;
      end
      // Flow characters are consumed; special characters are stored
      store_q.valid <= RX_IN.valid && (!fc_char || special);
      store_q.data  <= RX_IN.data;
    end
  end

  // Level crossings request a pause or resume sequence from the sender
  wire send_pause  = tx_sel != 2'b00 && lvl_hi && !xoff_prev_q;
  wire send_resume = tx_sel != 2'b00 && lvl_lo && xoff_prev_q;
  wire fc_take     = fc_q.valid && TX_FC_READY;

  always_comb begin
    snd_d = snd_q;
    case (snd_q)
      SND_IDLE: begin
        if (send_pause || send_resume) begin
          snd_d = tx_sel[1] ? SND_FIRST : SND_SECOND;
        end
      end
      SND_FIRST: begin
        if (fc_take) begin
          snd_d = tx_sel[0] ? SND_SECOND : SND_IDLE;
        end
      end
      SND_SECOND: begin
        if (fc_take) snd_d = SND_IDLE;
      end
      default: snd_d = SND_IDLE;
    endcase
  end

  // Flow character output register
  // Stored pause choice only lands with the first character, so use the request then
  wire       pick_pause = (snd_q == SND_IDLE) ? send_pause : snd_pause_q;
  wire [7:0] fc_char_d  = (snd_d == SND_FIRST) ? (pick_pause ? pau1_q : res1_q)
                                               : (pick_pause ? pau2_q : res2_q);
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      snd_q       <= SND_IDLE;
      snd_pause_q <= 1'b0;
      xoff_prev_q <= 1'b0;
      fc_q        <= '0;
    end else begin
      snd_q <= snd_d;
      if (snd_q == SND_IDLE && (send_pause || send_resume)) begin
        snd_pause_q <= send_pause;
        xoff_prev_q <= send_pause;
      end
      if (snd_d != snd_q || fc_take) begin
        fc_q.valid <= snd_d != SND_IDLE;
        fc_q.data  <= fc_char_d;
      end
    end
  end

  // Interrupt level from unmasked sticky bits
  // Next mask value, so a mask write moves the level in the same cycle as the register
  wire [7:0] mask_d = (wr_done && PADDR == OFS_MASK) ? wd : mask_q;
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) irq_q <= 1'b0;
    else         irq_q <= |(stat_d & mask_d);
  end

  assign PRDATA   = prdata_q;
  assign PREADY   = pready_q;
  assign PSLVERR  = pslverr_q;
  assign IRQ      = irq_q;
  assign RTS_PIN  = rts_q;
  assign TX_HALT  = halt_q;
  assign RX_STORE = store_q;
  assign TX_FC    = fc_q;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  cts_halt_a: assert property (enh_q[ENH_AUTO_CTS] && cts_q && !TX_BUSY |=> TX_HALT)
    else $error("Transmitter not halted on CTS");
  no_midchar_a: assert property (TX_BUSY && !halt_q |=> !TX_HALT)
    else $error("Halt asserted during a character");
  rts_high_a: assert property (enh_q[ENH_AUTO_RTS] && lvl_hi ##1 enh_q[ENH_AUTO_RTS]
                               |=> RTS_PIN)
    else $error("RTS not raised at high level");
  rts_low_a: assert property (enh_q[ENH_AUTO_RTS] && lvl_lo && !lvl_hi
                              ##1 enh_q[ENH_AUTO_RTS] |=> !RTS_PIN)
    else $error("RTS not released below low level");
  rts_soft_a: assert property (!enh_q[ENH_AUTO_RTS] |=>
                               RTS_PIN == !$past(modem_q[MODEM_RTS]))
    else $error("RTS not following modem control");
  special_flag_a: assert property (special |=> stat_q[ST_SPECIAL] && RX_STORE.valid)
    else $error("Special character not flagged and stored");
  lock_irqen_a: assert property (wr_done && PADDR == OFS_IRQEN && !gate |=>
                                 irqen_q[7:4] == $past(irqen_q[7:4]))
    else $error("Locked enhanced bits changed");
  gate_reset_a: assert property ($fell(SYS_RST) |-> enh_q == RST_BYTE)
    else $error("Gate bit not clear after reset");
  apb_wait_a: assert property (acc && !pready_q |=> PREADY ##1 !PREADY)
    else $error("APB answer timing wrong");
  irq_level_a: assert property (|(stat_q & mask_q) |-> IRQ)
    else $error("Interrupt missing for unmasked status");

  cov_cts_halt_c:  cover property (!TX_HALT ##1 TX_HALT ##[1:20] !TX_HALT);
  cov_dual_send_c: cover property (snd_q == SND_FIRST ##[1:10] snd_q == SND_SECOND);
  cov_special_c:   cover property (special);
  cov_rts_cycle_c: cover property (RTS_PIN ##[1:50] !RTS_PIN);
  cov_dual_rx_c:   cover property (dual_rx && p_hit);

endmodule

// ==== common/uefc_pkg.sv ====
// Constants, register map and carriers for the enhanced flow control block.
// Assumes a 100 MHz single clock domain and an APB master with 32-bit data.
// Summary of operation
// - Auto CTS halts transmitter while CTS high
// - Auto RTS: interrupt at trigger, RTS high
// - RTS returns low below lower threshold
// - Flow control off: RTS follows modem control
// - Auto RTS bit reads back flow state
// - Special detect: match second pause, flag
// - Character bit 0 compares register bit 0
// - Gate bit opens enhanced bits, clear locks
// - Gate bit reads zero after reset
// - Low four bits select software flow
// - Dual modes use consecutive two-character sequence; receive uses it only with all four select bits set
// - Bits 3:2 transmit, 1:0 receive select
package uefc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_ENH    = 8'h00;
  localparam logic [7:0] OFS_RES1   = 8'h04;
  localparam logic [7:0] OFS_RES2   = 8'h08;
  localparam logic [7:0] OFS_PAU1   = 8'h0C;
  localparam logic [7:0] OFS_PAU2   = 8'h10;
  localparam logic [7:0] OFS_IRQEN  = 8'h14;
  localparam logic [7:0] OFS_FIFOC  = 8'h18;
  localparam logic [7:0] OFS_MODEM  = 8'h1C;
  localparam logic [7:0] OFS_RXTRIG = 8'h20;
  localparam logic [7:0] OFS_FLOWHI = 8'h24;
  localparam logic [7:0] OFS_FLOWLO = 8'h28;
  localparam logic [7:0] OFS_STAT   = 8'h2C;
  localparam logic [7:0] OFS_MASK   = 8'h30;
  localparam logic [7:0] OFS_STATE  = 8'h34;
  // Enhanced feature control fields
  localparam int ENH_AUTO_CTS = 7;
  localparam int ENH_AUTO_RTS = 6;
  localparam int ENH_SPECIAL  = 5;
  localparam int ENH_GATE     = 4;
  // Status bit positions
  localparam int ST_RXTRIG  = 0;
  localparam int ST_CTSCHG  = 1;
  localparam int ST_RTSCHG  = 2;
  localparam int ST_SPECIAL = 4;
  localparam int ST_FLOWCH  = 5;
  // Modem control bit for software RTS
  localparam int MODEM_RTS = 1;
  // Lockable masks
  localparam logic [7:0] IRQEN_LOCK = 8'hF0;
  localparam logic [7:0] FIFOC_LOCK = 8'h30;
  localparam logic [7:0] MODEM_LOCK = 8'hE0;
  localparam logic [7:0] ST_LOCK  = 8'h30;
  // Reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // Character carrier
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } uefc_char_s;
  // Flow character sender states
  typedef enum logic [2:0] {
    SND_IDLE   = 3'b001,
    SND_FIRST  = 3'b010,
    SND_SECOND = 3'b100
  } uefc_snd_e;
endpackage

// ==== bench/uefc_remote.sv ====
// Remote serial device model: drives the CTS handshake line, takes flow characters.
// Assumes the bench sets stop_req and stall just after REF_CLK rising edges.
`timescale 1ns/1ps
module uefc_remote
  import uefc_pkg::*;
(
  input  wire logic       REF_CLK,
  input  wire logic       SYS_RST,
  input  wire logic       stop_req,
  input  wire logic [1:0] stall,
  input  wire uefc_char_s TX_FC,
  output logic            TX_FC_READY,
  output logic            CTS_PIN
);
  logic [7:0] got[$];
  logic [1:0] wait_q;

  // Handshake line: 1 asks the device to stop sending
  always @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) CTS_PIN <= 1'b0;
    else CTS_PIN <= stop_req;
  end

  // Takes flow characters; stalls so a held character must stay put
  always @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      TX_FC_READY <= 1'b0;
      wait_q      <= 2'h0;
    end else if (TX_FC.valid && TX_FC_READY) begin
      got.push_back(TX_FC.data);  // Logged in arrival order
      TX_FC_READY <= 1'b0;
      wait_q      <= stall;
    end else if (TX_FC.valid) begin
      if (wait_q == 2'h0) TX_FC_READY <= 1'b1;
      else wait_q <= wait_q - 2'h1;
    end
  end
endmodule

// ==== bench/uefc_top_test.sv ====
// Self-checking bench for the enhanced flow control block, driven over APB.
// Assumes the remote model uefc_remote on the far side and one 100 MHz clock.
`timescale 1ns/1ps
module uefc_top_test
  import uefc_pkg::*;
;
  localparam logic [7:0] LK_OFS [3] = '{OFS_IRQEN, OFS_FIFOC, OFS_MODEM};
  localparam logic [7:0] LK_MSK [3] = '{IRQEN_LOCK, FIFOC_LOCK, MODEM_LOCK};
  logic        clk, rst, psel, pen, pwr, pready, pslverr, irq, cts, rts, busy, halt, rdy, stop;
  logic [7:0]  paddr, lvl;
  logic [31:0] pwdata, prdata, q;
  logic [1:0]  stall;
  uefc_char_s  rx_in, rx_st, tx_fc;
  int          failures = 0;
  int          n_tests = 0;
  int          cycles = 0;

  uefc_top dut (.REF_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .IRQ(irq), .CTS_PIN(cts), .RTS_PIN(rts), .RX_LEVEL(lvl), .RX_IN(rx_in), .RX_STORE(rx_st),
    .TX_BUSY(busy), .TX_HALT(halt), .TX_FC(tx_fc), .TX_FC_READY(rdy));
  uefc_remote far (.REF_CLK(clk), .SYS_RST(rst), .stop_req(stop), .stall(stall),
    .TX_FC(tx_fc), .TX_FC_READY(rdy), .CTS_PIN(cts));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Hang guard: the whole sequence needs well under this many cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      test_done();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input string what, input logic [31:0] want, input logic [31:0] got);
    n_tests++;
    if (got !== want) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, want, got);
    end
  endtask

  // One APB transfer, request held until PREADY is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    chk("slave error", {31'h0, a > OFS_STATE}, {31'h0, pslverr});
    psel <= 1'b0;
    pen  <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] want, input string what);
    apb(1'b0, a, 32'h0);
    chk(what, want, q);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  // One received character; the store pulse stands one cycle after it
  task automatic rx(input logic [7:0] c, input logic want_v);
    rx_in <= '{valid: 1'b1, data: c};
    @(posedge clk);
    rx_in <= '0;
    #1;
    chk("stored valid", {31'h0, want_v}, {31'h0, rx_st.valid});
    if (want_v) chk("stored data", {24'h0, c}, {24'h0, rx_st.data});
    @(posedge clk);
  endtask

  // Main sequence
  initial begin
    logic [7:0] want[$];
    {psel, pen, pwr, paddr, pwdata, busy, stop, stall, lvl} = '0;
    rx_in = '0;
    rst = 1'b1;
    cyc(12);
    rst <= 1'b0;
    cyc(1);
    chk("rts reset", 1, rts);
    rd(OFS_ENH, RST_WORD, "gate reset");
    for (int a = 4; a <= 8'h30; a += 4) rd(a[7:0], RST_WORD, "reset value");
    rd(8'h38, 32'h0, "unmapped read");
    // Enhanced bits locked until the gate opens
    foreach (LK_OFS[i]) begin
      wr(LK_OFS[i], 8'hFF);
      rd(LK_OFS[i], {24'h0, ~LK_MSK[i]}, "locked write");
      wr(OFS_ENH, 8'h10);
      wr(LK_OFS[i], 8'hFF);
      rd(LK_OFS[i], 32'h0000_00FF, "open write");
      wr(OFS_ENH, 8'h00);
      wr(LK_OFS[i], 8'h00);
      rd(LK_OFS[i], {24'h0, LK_MSK[i]}, "latched value");
    end
    wr(OFS_ENH, 8'h10);
    foreach (LK_OFS[i]) wr(LK_OFS[i], 8'h00);
    wr(OFS_ENH, 8'h00);
    wr(OFS_MODEM, 8'h02);
    cyc(3);
    chk("rts software low", 0, rts);
    wr(OFS_MODEM, 8'h00);
    cyc(3);
    chk("rts software high", 1, rts);
    // Auto CTS; a character in flight defers the halt
    busy <= 1'b1;
    stop <= 1'b1;
    cyc(6);
    chk("halt disabled", 0, halt);
    wr(OFS_ENH, 8'h80);
    cyc(6);
    chk("halt while busy", 0, halt);
    busy <= 1'b0;
    cyc(5);
    chk("halt", 1, halt);
    stop <= 1'b0;
    cyc(6);
    chk("resume", 0, halt);
    // Auto RTS between the two thresholds
    wr(OFS_FLOWHI, 8'h04);
    wr(OFS_FLOWLO, 8'h02);
    wr(OFS_RXTRIG, 8'h04);
    wr(OFS_MASK, 8'h01);
    wr(OFS_MODEM, 8'h02);
    wr(OFS_ENH, 8'h40);
    lvl <= 8'h03;
    cyc(4);
    chk("rts below", 0, rts);
    lvl <= 8'h04;
    cyc(4);
    chk("rts held", 1, rts);
    chk("irq trigger", 1, irq);
    rd(OFS_ENH, 32'h0, "auto rts held");
    lvl <= 8'h02;
    cyc(4);
    chk("rts at low", 1, rts);
    lvl <= 8'h01;
    cyc(4);
    chk("rts released", 0, rts);
    rd(OFS_ENH, 32'h0000_0040, "auto rts free");
    wr(OFS_MASK, 8'h00);
    cyc(2);
    chk("irq masked", 0, irq);
    wr(OFS_STAT, 8'h07);
    rd(OFS_STAT, 32'h0, "status cleared");
    wr(OFS_ENH, 8'h00);
    wr(OFS_MODEM, 8'h00);
    lvl <= 8'h00;
    // Special character, bit 0 against bit 0
    wr(OFS_PAU2, 8'h01);
    wr(OFS_MASK, 8'h10);
    wr(OFS_ENH, 8'h30);                                       // Select bits zero
    rx(8'h80, 1'b1);
    cyc(2);
    chk("irq no match", 0, irq);
    rx(8'h01, 1'b1);
    cyc(2);
    chk("irq special", 1, irq);
    rd(OFS_STAT, 32'h0000_0010, "special flag");
    wr(OFS_STAT, 8'h10);
    cyc(2);
    chk("irq cleared", 0, irq);
    wr(OFS_ENH, 8'h00);
    // Receiver compares the first pair; flow characters are not stored
    wr(OFS_PAU1, 8'h13);
    wr(OFS_RES1, 8'h11);
    wr(OFS_ENH, 8'h02);
    rx(8'h13, 1'b0);
    rx(8'h11, 1'b0);
    rx(8'h55, 1'b1);                                          // Plain data only
    wr(OFS_ENH, 8'h00);
    wr(OFS_RES2, 8'h12);
    wr(OFS_PAU2, 8'h14);
    // Dual receive: a pause pair halts, a resume pair releases
    wr(OFS_ENH, 8'h0F);
    rx(8'h13, 1'b0);
    rx(8'h14, 1'b0);
    rd(OFS_STATE, 32'h0000_000E, "dual pause");
    rx(8'h11, 1'b0);
    rx(8'h12, 1'b0);
    rd(OFS_STATE, 32'h0000_0002, "dual resume");
    wr(OFS_ENH, 8'h00);
    // Transmit selections 01, 10, 11 with the far side stalling
    for (int m = 1; m <= 3; m++) begin
      stall <= m[1:0];
      lvl <= 8'h03;
      wr(OFS_ENH, {4'h0, m[1:0], 2'h0});
      want.delete();
      far.got.delete();
      if (m[1]) want.push_back(8'h13);
      if (m[0]) want.push_back(8'h14);
      if (m[1]) want.push_back(8'h11);
      if (m[0]) want.push_back(8'h12);
      lvl <= 8'h05;
      cyc(30);
      lvl <= 8'h00;
      cyc(30);
      chk("flow count", want.size(), far.got.size());
      foreach (want[i]) chk("flow char", {24'h0, want[i]}, {24'h0, far.got[i]});
      wr(OFS_ENH, 8'h00);
    end
    test_done();
  end
endmodule
